// File: inc/disk_port_pkg.sv
// Constants and carrier types for the hard disk DMA port.
// Assumes a 100 MHz system clock and a byte-wide external disk bus.
package disk_port_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ACK_MAX_NS    = 250;
  // Longest time rounds down to whole cycles.
  localparam int unsigned ACK_MAX_CYC   = ACK_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned FIFO_DEPTH    = 32;
  localparam int unsigned FIFO_AW       = 5;
  localparam logic [7:0]  DATA_RESET    = 8'h00;

  // Command byte request from the host side.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       first;
  } cmd_req_t;

  // One byte on the memory side stream.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } mem_byte_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CMD  = 4'h2,
    ST_ACK  = 4'h4,
    ST_WAIT = 4'h8
  } port_state_t;
endpackage

// File: core/byte_fifo.sv
// Byte FIFO that holds data between the disk bus and memory.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/100ps
module byte_fifo (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       flush,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_data
);
  logic [7:0]                         mem [disk_port_pkg::FIFO_DEPTH];
  logic [disk_port_pkg::FIFO_AW-1:0] wr_ptr;
  logic [disk_port_pkg::FIFO_AW-1:0] rd_ptr;
  logic [disk_port_pkg::FIFO_AW:0]   count;
  logic [disk_port_pkg::FIFO_AW-1:0] next_wr_ptr;
  logic [disk_port_pkg::FIFO_AW-1:0] next_rd_ptr;
  logic [disk_port_pkg::FIFO_AW:0]   next_count;
  logic                               push;
  logic                               pop;

  // Full and empty follow the occupancy count.
  assign in_ready  = (count != 6'(disk_port_pkg::FIFO_DEPTH));
  assign out_valid = (count != 6'h00);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count next values.
  always_comb begin
    next_wr_ptr = wr_ptr + 5'(push);
    next_rd_ptr = rd_ptr + 5'(pop);
    next_count  = count + 6'(push) - 6'(pop);
    if (flush) begin
      next_wr_ptr = 5'h00;
      next_rd_ptr = 5'h00;
      next_count  = 6'h00;
    end
  end

  // Pointer registers.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= 5'h00;
      rd_ptr <= 5'h00;
      count  <= 6'h00;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage array, written on push only.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // byte_fifo

// File: core/hard_disk_dma_port.sv
// Host-side hard disk DMA port: command bytes out, then paced DMA data.
// Assumes the disk controller pins are synchronous to ref_clk.
`timescale 1ns/100ps
module hard_disk_dma_port (
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  input  wire disk_port_pkg::cmd_req_t cmd_req,
  output logic                         cmd_ready,
  input  wire logic                    dma_enable,
  input  wire logic                    dma_to_disk,
  input  wire disk_port_pkg::mem_byte_t mem_wr,
  output logic                         mem_wr_ready,
  output disk_port_pkg::mem_byte_t     mem_rd,
  input  wire logic                    mem_rd_ready,
  output logic                         disk_target_select_n,
  output logic                         disk_phase_select,
  output logic                         disk_ack_n,
  output logic                         disk_read_n_write,
  output logic [7:0]                   disk_data_out,
  output logic                         disk_data_oe_n,
  input  wire logic [7:0]              disk_data_in,
  input  wire logic                    disk_transfer_request,
  input  wire logic                    disk_completion_interrupt,
  output logic                         irq_to_controller
);
  disk_port_pkg::port_state_t state;
  disk_port_pkg::port_state_t next_state;
  logic [7:0] data_q;
  logic [7:0] next_data_q;
  logic       sel_n;
  logic       next_sel_n;
  logic       phase;
  logic       next_phase;
  logic       ack_n;
  logic       next_ack_n;
  logic       oe_n;
  logic       next_oe_n;
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic [7:0] fifo_in_data;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic       take_disk;
  logic       give_disk;

  // Disk-to-memory bytes enter the buffer from the bus; memory-to-disk
  // bytes enter from the memory controller.
  assign fifo_in_valid  = dma_to_disk ? mem_wr.valid : take_disk;
  assign fifo_in_data   = dma_to_disk ? mem_wr.data : disk_data_in;
  assign mem_wr_ready   = dma_to_disk && fifo_in_ready;
  assign fifo_out_ready = dma_to_disk ? give_disk : mem_rd_ready;
  assign mem_rd.valid   = !dma_to_disk && fifo_out_valid;
  assign mem_rd.data    = fifo_out_data;

  // Buffer that rides out memory stalls at full bus rate.
  byte_fifo u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .flush     (!dma_enable),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // A request is served only when the buffer can give or take a byte.
  assign take_disk = (state == disk_port_pkg::ST_IDLE) && dma_enable && !dma_to_disk
                     && disk_transfer_request && fifo_in_ready;
  assign give_disk = (state == disk_port_pkg::ST_IDLE) && dma_enable && dma_to_disk
                     && disk_transfer_request && fifo_out_valid;
  assign cmd_ready = (state == disk_port_pkg::ST_IDLE) && !dma_enable;

  // Next-state logic for the handshake sequencer.
  always_comb begin
    next_state  = state;
    next_data_q = data_q;
    next_sel_n  = 1'b1;
    next_phase  = 1'b0;
    next_ack_n  = 1'b1;
    next_oe_n   = oe_n;
    case (state)
      disk_port_pkg::ST_IDLE: begin
        if (cmd_req.valid && cmd_ready) begin
          next_state  = disk_port_pkg::ST_CMD;
          next_data_q = cmd_req.data;
          next_sel_n  = 1'b0;
          next_phase  = 1'b1;
          next_oe_n   = 1'b0;
        end else if (take_disk || give_disk) begin
          next_state  = disk_port_pkg::ST_ACK;
          next_ack_n  = 1'b0;
          next_data_q = give_disk ? fifo_out_data : data_q;
          next_oe_n   = !dma_to_disk;
        end else begin
          next_oe_n = !(dma_enable && dma_to_disk);
        end
      end
      disk_port_pkg::ST_CMD: begin
        next_state = disk_port_pkg::ST_WAIT;
      end
      disk_port_pkg::ST_ACK: begin
        next_state = disk_port_pkg::ST_WAIT;
      end
      disk_port_pkg::ST_WAIT: begin
        // Wait for the request to drop so one byte pairs with one handshake.
        if (!disk_transfer_request || !dma_enable) begin
          next_state = disk_port_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = disk_port_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer and pin registers.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state  <= disk_port_pkg::ST_IDLE;
      data_q <= disk_port_pkg::DATA_RESET;
      sel_n  <= 1'b1;
      phase  <= 1'b0;
      ack_n  <= 1'b1;
      oe_n   <= 1'b1;
    end else begin
      state  <= next_state;
      data_q <= next_data_q;
      sel_n  <= next_sel_n;
      phase  <= next_phase;
      ack_n  <= next_ack_n;
      oe_n   <= next_oe_n;
    end
  end

  // Pin outputs; completion interrupt passes straight to the controller.
  assign disk_target_select_n = sel_n;
  assign disk_phase_select    = phase;
  assign disk_ack_n           = ack_n;
  assign disk_read_n_write    = !(dma_enable && dma_to_disk) && sel_n;
  assign disk_data_out        = data_q;
  assign disk_data_oe_n       = oe_n;
  assign irq_to_controller    = disk_completion_interrupt;

  // Cycles that a request the port is able to serve has waited in idle.
  logic [7:0] wait_cyc;
  logic [7:0] next_wait_cyc;

  // Next wait count; it clears as soon as the sequencer leaves idle.
  always_comb begin
    next_wait_cyc = 8'h00;
    if ((state == disk_port_pkg::ST_IDLE) && dma_enable && disk_transfer_request
        && (dma_to_disk ? fifo_out_valid : fifo_in_ready)) begin
      next_wait_cyc = (wait_cyc == 8'hFF) ? wait_cyc : wait_cyc + 8'h01;
    end
  end

  // Wait counter register, only read by the timing check below.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_cyc <= 8'h00;
    end else begin
      wait_cyc <= next_wait_cyc;
    end
  end

  // Acknowledge comes within the allowed time of a served request.
  ack_timely_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (take_disk || give_disk) |=> !disk_ack_n)
    else $error("acknowledge late after request");

  // A servable request never waits longer than the acknowledge limit.
  wait_bound_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wait_cyc < 8'(disk_port_pkg::ACK_MAX_CYC))
    else $error("request left waiting too long");

  // Acknowledge is a single-cycle low pulse.
  ack_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !disk_ack_n |=> disk_ack_n)
    else $error("acknowledge held too long");

  // The port drives the bus during a write acknowledge and floats it on a read.
  bus_drive_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !disk_ack_n |-> (disk_data_oe_n == disk_read_n_write))
    else $error("bus drive wrong for transfer direction");

  // Acknowledge never happens without a request.
  ack_paced_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(disk_ack_n) |-> $past(disk_transfer_request))
    else $error("acknowledge without request");

  // Command writes drive select low and phase high together.
  cmd_select_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !disk_target_select_n |-> disk_phase_select && !disk_data_oe_n)
    else $error("command write pins wrong");

  // Each command byte gets a select pulse of one cycle.
  cmd_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !disk_target_select_n |=> disk_target_select_n)
    else $error("select held too long");

  // A dropped request frees the sequencer at once, keeping the byte rate up.
  wait_release_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == disk_port_pkg::ST_WAIT) && !disk_transfer_request
      |=> (state == disk_port_pkg::ST_IDLE))
    else $error("sequencer slow to rearm");

  // Leaving DMA empties the buffer so no stale byte is sent later.
  flush_empty_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !dma_enable |=> !fifo_out_valid)
    else $error("buffer not emptied on flush");

  // Memory sees a byte only when the buffer holds one.
  mem_side_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mem_rd.valid |-> !dma_to_disk && fifo_out_valid)
    else $error("memory byte without buffered data");
endmodule // hard_disk_dma_port

// File: test/disk_ctrl_model.sv
// Behavioural off-board disk controller on the far side of the port.
// Assumes its pins are synchronous to ref_clk; the bench sets active and slow.
`timescale 1ns/100ps
module disk_ctrl_model (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       active,
  input  wire logic       slow,
  input  wire logic       select_n,
  input  wire logic       phase,
  input  wire logic       ack_n,
  input  wire logic       rnw,
  input  wire logic [7:0] bus_out,
  output logic            req,
  output logic [7:0]      bus_in,
  output logic            rx_stb,
  output logic            rx_cmd,
  output logic [7:0]      rx_byte,
  output logic [7:0]      lat,
  output logic            stray
);
  logic [7:0] tx_byte;
  logic [2:0] gap;
  // Offered byte, or a flipped copy once the model stops offering.
  assign bus_in  = active ? tx_byte : ~tx_byte;
  assign stray   = !ack_n && !req;
  assign rx_stb  = !select_n || (!ack_n && !rnw);
  assign rx_cmd  = !select_n && phase && !rnw;
  assign rx_byte = bus_out;
  // Raises the request, drops it on acknowledge, then pauses if slow.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req     <= 1'b0;
      gap     <= 3'h0;
      tx_byte <= 8'h5A;
      lat     <= 8'h00;
    end else if (!ack_n) begin
      req <= 1'b0;
      gap <= slow ? 3'h5 : 3'h0;
      if (rnw) tx_byte <= 8'($urandom);
    end else if (gap != 3'h0) begin
      gap <= gap - 3'h1;
    end else begin
      req <= active;
      lat <= req ? lat + 8'h01 : 8'h00;
    end
  end
endmodule // disk_ctrl_model

// File: test/test_hard_disk_dma_port.sv
// Self-checking bench for the hard disk DMA port with a queue model.
// Assumes disk_port_pkg and disk_ctrl_model are compiled first.
`timescale 1ns/100ps
module test_hard_disk_dma_port;
  logic ref_clk, sys_rst, cmd_ready, dma_enable, dma_to_disk, mem_wr_ready;
  logic mem_rd_ready, sel_n, phase, ack_n, rnw, oe_n, req, intr, irq;
  logic active, slow, stall, rx_stb, rx_cmd, stray;
  logic [7:0] dout, din, rx_byte, lat;
  disk_port_pkg::cmd_req_t  cmd_req;
  disk_port_pkg::mem_byte_t mem_wr, mem_rd;
  logic [7:0] exp_q[$], dsk_q[$], cmd_q[$];
  int n_errors, compares, acks, wr_left;
  bit blocked;
  hard_disk_dma_port dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_req(cmd_req),
    .cmd_ready(cmd_ready), .dma_enable(dma_enable), .dma_to_disk(dma_to_disk),
    .mem_wr(mem_wr), .mem_wr_ready(mem_wr_ready), .mem_rd(mem_rd),
    .mem_rd_ready(mem_rd_ready), .disk_target_select_n(sel_n), .disk_phase_select(phase),
    .disk_ack_n(ack_n), .disk_read_n_write(rnw), .disk_data_out(dout),
    .disk_data_oe_n(oe_n), .disk_data_in(din), .disk_transfer_request(req),
    .disk_completion_interrupt(intr), .irq_to_controller(irq));
  disk_ctrl_model far_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .active(active),
    .slow(slow), .select_n(sel_n), .phase(phase), .ack_n(ack_n), .rnw(rnw),
    .bus_out(dout), .req(req), .bus_in(din), .rx_stb(rx_stb), .rx_cmd(rx_cmd),
    .rx_byte(rx_byte), .lat(lat), .stray(stray));
  // Free-running 100 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task wrap_up;
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %0t byte %h want %h", $time, got, exp);
    end
  endtask
  task chkb(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %0t flag %b want %b", $time, got, exp);
    end
  endtask
  function automatic bit done(input int code);
    case (code)
      0: return cmd_ready === 1'b1;
      1: return acks >= 100 && req === 1'b0;
      2: return exp_q.size() == 0;
      default: return wr_left == 0 && dsk_q.size() == 0;
    endcase
  endfunction
  // Bounded wait on one of the conditions above.
  task await(input int code, input int lim);
    for (int k = 0; k <= lim; k++) begin
      @(posedge ref_clk);
      if (done(code)) return;
    end
    n_errors++;
    $display("mismatch %0t wait %0d timed out", $time, code);
    wrap_up();
  endtask
  task send_cmd(input logic [7:0] b);
    await(0, 50);
    cmd_q.push_back(b);
    cmd_req <= '{1'b1, b, 1'b0};
    @(posedge ref_clk);
    cmd_req.valid <= 1'b0;
  endtask
  // Memory side streams, model queues and far-side comparisons.
  always @(posedge ref_clk) begin
    if (!ack_n && !dma_to_disk) begin
      // A request held off by a full buffer has no time limit.
      if (!blocked) chkb(lat <= disk_port_pkg::ACK_MAX_CYC, 1'b1);
      blocked = 1'b0;
    end
    if (!ack_n && rnw) exp_q.push_back(din);
    if (exp_q.size() >= disk_port_pkg::FIFO_DEPTH) blocked = 1'b1;
    if (mem_rd.valid && mem_rd_ready) chk8(mem_rd.data, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    mem_rd_ready <= stall ? 1'b0 : 1'($urandom);
    if (mem_wr.valid && mem_wr_ready) begin
      dsk_q.push_back(mem_wr.data);
      mem_wr.data <= 8'($urandom);
      mem_wr.valid <= wr_left > 1;
      wr_left--;
    end
    if (rx_stb && rx_cmd) chk8(rx_byte, cmd_q.size() ? cmd_q.pop_front() : 8'hXX);
    if (rx_stb && !rx_cmd) chk8(rx_byte, dsk_q.size() ? dsk_q.pop_front() : 8'hXX);
    if (!ack_n) acks++;
    if (!ack_n) chkb(oe_n, !dma_to_disk);
    if (!sel_n) chkb(oe_n, 1'b0);
    if (stray) chkb(1'b0, 1'b1);
  end
  // Main sequence: commands, refusal, both DMA directions, interrupt.
  initial begin
    void'($urandom(58376));
    {sys_rst, dma_enable, dma_to_disk, mem_rd_ready, intr} = 5'h10;
    {active, slow, stall, cmd_req, mem_wr} = '0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) send_cmd(8'($urandom));
    await(0, 50);
    dma_enable <= 1'b1;
    @(posedge ref_clk);
    @(posedge ref_clk);
    chkb(cmd_ready, 1'b0);
    stall = 1'b1;
    active <= 1'b1;
    repeat (150) @(posedge ref_clk);
    chkb(acks == disk_port_pkg::FIFO_DEPTH, 1'b1);
    stall = 1'b0;
    slow <= 1'b1;
    await(1, 3000);
    active <= 1'b0;
    await(1, 20);
    await(2, 300);
    dma_enable <= 1'b0;
    dma_to_disk <= 1'b1;
    @(posedge ref_clk);
    dma_enable <= 1'b1;
    active <= 1'b1;
    slow <= 1'b0;
    wr_left = 40;
    mem_wr <= '{1'b1, 8'($urandom)};
    await(3, 4000);
    active <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      intr <= 1'(i);
      @(posedge ref_clk);
      @(posedge ref_clk);
      chkb(irq, 1'(i));
    end
    wrap_up();
  end
endmodule // test_hard_disk_dma_port
